//--- shared/logic_out_pkg.sv
package logic_out_pkg;
  // sizes of the block
  localparam int NUM_GPI    = 8;    // general inputs
  localparam int NUM_RAIL   = 10;   // rail status flags
  localparam int NUM_OUT    = 8;    // logic outputs, all fed back into the terms
  localparam int NUM_SEL    = 3;    // rail state selection bits
  localparam int ADR_W      = 8;    // byte address width on the bus
  localparam int DLY_W      = 16;   // delay field width, in timebase ticks

  // timebase: one tick every TICK_US microseconds at CLK_MHZ
  localparam int CLK_MHZ     = 50;
  localparam int TICK_US     = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  // register byte offsets
  localparam logic [7:0] ADR_POLARITY = 8'h00;  // polarity and defined-input mask
  localparam logic [7:0] ADR_FUNC     = 8'h04;  // special input function assignment
  localparam logic [7:0] ADR_STATUS   = 8'h08;  // live state, sticky fault flag
  localparam logic [7:0] ADR_LATCH    = 8'h0C;  // latched rail flags, write one to clear
  localparam logic [7:0] ADR_OUT_BASE = 8'h40;  // first logic_output_setup_command block
  localparam logic [7:0] ADR_OUT_END  = 8'hC0;  // first byte past the output blocks
  localparam logic [1:0] SUB_TERM0    = 2'h0;   // AND path 0
  localparam logic [1:0] SUB_TERM1    = 2'h1;   // AND path 1
  localparam logic [1:0] SUB_CFG      = 2'h2;   // delay and mode setup

  // polarity register fields
  localparam int POL_LSB = 0;
  localparam int DEF_LSB = 8;
  localparam logic [31:0] POLARITY_RST = 32'h0000_00FF;

  // special function register: one 4-bit slot per function, {valid, pin[2:0]}
  localparam int FN_W        = 4;
  localparam int FN_VALID    = 3;
  localparam int FN_FAULT    = 0;
  localparam int FN_LATCHCLR = 1;
  localparam int FN_MRG_EN   = 2;
  localparam int FN_MRG_LOW  = 3;

  // AND term fields
  localparam int TERM_GPI_LSB   = 0;
  localparam int TERM_OUT_LSB   = 8;
  localparam int TERM_RAIL_LSB  = 16;
  localparam int TERM_LATCH_BIT = 26;

  // output setup fields
  localparam int CFG_DLY_ASSERT   = 0;
  localparam int CFG_DLY_DEASSERT = 1;
  localparam int CFG_IGNORE       = 2;
  localparam int CFG_SM_MODE      = 3;
  localparam int CFG_DLY_LSB      = 16;

  // status register fields
  localparam int ST_FAULT   = 0;
  localparam int ST_GPI_LSB = 8;
  localparam int ST_OUT_LSB = 16;
  localparam int ST_MRG_EN  = 24;
  localparam int ST_MRG_LOW = 25;
  localparam int ST_SEL_LSB = 28;
endpackage : logic_out_pkg

//--- core/logic_out_block.sv
`timescale 1ns/10ps
module logic_out_block
  import logic_out_pkg::*;
#(
  parameter int TICK_CYCLES_P = logic_out_pkg::TICK_CYCLES  // shorten in simulation
) (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // classic wishbone slave
  input  wire logic                                cyc_i,
  input  wire logic                                stb_i,
  input  wire logic                                we_i,
  input  wire logic [logic_out_pkg::ADR_W-1:0]     adr_i,
  input  wire logic [3:0]                          sel_i,
  input  wire logic [31:0]                         dat_i,
  output logic      [31:0]                         dat_o,
  output logic                                     ack_o,
  // pins and rail flags
  input  wire logic [logic_out_pkg::NUM_GPI-1:0]   gpi_pin_i,
  input  wire logic [logic_out_pkg::NUM_RAIL-1:0]  rail_status_i,
  input  wire logic [logic_out_pkg::NUM_RAIL-1:0]  rail_event_i,
  output logic      [logic_out_pkg::NUM_OUT-1:0]   logic_out_o,
  output logic                                     fault_o,
  output logic                                     margin_en_o,
  output logic                                     margin_low_o,
  output logic      [logic_out_pkg::NUM_SEL-1:0]   pin_chosen_rail_state_o
);
  import logic_out_pkg::*;

  localparam int TCNT_W = $clog2(TICK_CYCLES_P + 1);

  // merge a bus write into a word under byte enables
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge_sel = (old_v & ~m) | (new_v & m);
  endfunction : merge_sel

  // decode an output block address into {hit, index, sub-register}
  function automatic logic [5:0] out_slot(input logic [ADR_W-1:0] a);
    logic [ADR_W-1:0] off;
    off = a - ADR_OUT_BASE;
    out_slot = {(a >= ADR_OUT_BASE) && (a < ADR_OUT_END), off[6:4], off[3:2]};
  endfunction : out_slot

  // one AND term; an empty term is false so it never forces the OR true
  function automatic logic and_term(input logic [31:0] t, input logic [NUM_GPI-1:0] g,
                                    input logic [NUM_OUT-1:0] o, input logic [NUM_RAIL-1:0] live,
                                    input logic [NUM_RAIL-1:0] held);
    logic [NUM_GPI-1:0]  gm;
    logic [NUM_OUT-1:0]  om;
    logic [NUM_RAIL-1:0] rm;
    logic [NUM_RAIL-1:0] rs;
    gm = t[TERM_GPI_LSB +: NUM_GPI];
    om = t[TERM_OUT_LSB +: NUM_OUT];
    rm = t[TERM_RAIL_LSB +: NUM_RAIL];
    rs = t[TERM_LATCH_BIT] ? held : live;
    and_term = ((gm != '0) || (om != '0) || (rm != '0))
               && ((g & gm) == gm) && ((o & om) == om) && ((rs & rm) == rm);
  endfunction : and_term

  // register storage
  logic [31:0]         polarity_r;            // polarity and defined mask
  logic [31:0]         func_r;                // special function slots
  logic [31:0]         term0_r [NUM_OUT];     // AND path 0 per output
  logic [31:0]         term1_r [NUM_OUT];     // AND path 1 per output
  logic [31:0]         cfg_r   [NUM_OUT];     // delay and mode per output
  logic [NUM_RAIL-1:0] latched_r;             // latched rail flags
  logic                fault_flag_r;          // sticky fault, write one to clear
  logic                ack_r;                 // bus acknowledge
  logic [31:0]         dat_r;                 // registered read data

  // pin synchronisers and settled input state
  logic [NUM_GPI-1:0]  sync1_r;
  logic [NUM_GPI-1:0]  sync2_r;
  logic [NUM_GPI-1:0]  sync3_r;
  logic [NUM_GPI-1:0]  gpi_r;                 // settled raw level
  logic [NUM_GPI-1:0]  gpi_act;               // after polarity
  logic [NUM_GPI-1:0]  gpi_act_d_r;           // previous active level

  logic [TCNT_W-1:0]   tbase_r;               // timebase divider
  logic                tick;                  // one-cycle timebase pulse
  logic [NUM_OUT-1:0]  out_r;                 // pin state of each output
  logic [NUM_OUT-1:0]  res_r;                 // undelayed logic result
  logic                fault_r;
  logic                mrg_en_r;
  logic                mrg_low_r;
  logic [NUM_SEL-1:0]  sel_nxt;
  logic [NUM_SEL-1:0]  sel_r;

  // bus strobes: a request is answered one cycle after it is seen
  logic       bus_req;
  logic       wr_fire;
  logic [5:0] wslot;
  assign bus_req = cyc_i & stb_i & ~ack_r;
  assign wr_fire = bus_req & we_i;
  assign wslot   = out_slot(adr_i);

  // special function pins; a single index per function means only one pin can own it
  logic [FN_W-1:0] fn_fault;
  logic [FN_W-1:0] fn_clr;
  logic [FN_W-1:0] fn_men;
  logic [FN_W-1:0] fn_mlow;
  assign fn_fault = func_r[FN_FAULT*FN_W +: FN_W];
  assign fn_clr   = func_r[FN_LATCHCLR*FN_W +: FN_W];
  assign fn_men   = func_r[FN_MRG_EN*FN_W +: FN_W];
  assign fn_mlow  = func_r[FN_MRG_LOW*FN_W +: FN_W];

  logic clr_in;
  logic men_in;
  logic mlow_in;
  assign clr_in  = fn_clr[FN_VALID]  & gpi_act[fn_clr[2:0]];
  assign men_in  = fn_men[FN_VALID]  & gpi_act[fn_men[2:0]];
  assign mlow_in = fn_mlow[FN_VALID] & gpi_act[fn_mlow[2:0]];

  // three-stage synchroniser; a level is taken only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= gpi_pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // settle each input bit separately
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpi_r <= '0;
    end else begin
      gpi_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (gpi_r & (sync2_r ^ sync3_r));
    end
  end

  // polarity: a set bit means active high
  assign gpi_act = ~(gpi_r ^ polarity_r[POL_LSB +: NUM_GPI]);

  // free-running timebase shared by all delay timers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbase_r <= '0;
    end else if (tbase_r == TCNT_W'(TICK_CYCLES_P - 1)) begin
      tbase_r <= '0;
    end else begin
      tbase_r <= tbase_r + 1'b1;
    end
  end
  assign tick = (tbase_r == TCNT_W'(TICK_CYCLES_P - 1));

  // per-output logic and delay engine
  genvar n;
  generate
    for (n = 0; n < NUM_OUT; n++) begin : g_out
      logic             t0;
      logic             t1;
      logic             res_nxt;
      logic             pend_r;           // a delayed change is in flight
      logic             tgt_r;            // level the pin moves to on expiry
      logic [DLY_W-1:0] cnt_r;            // ticks elapsed
      logic [DLY_W-1:0] dly;
      logic             ign;
      logic             want_dly;

      assign t0  = and_term(term0_r[n], gpi_act, out_r, rail_status_i, latched_r);
      assign t1  = and_term(term1_r[n], gpi_act, out_r, rail_status_i, latched_r);
      // state machine mode picks one path by the current result
      assign res_nxt = cfg_r[n][CFG_SM_MODE] ? (res_r[n] ? t0 : t1) : (t0 | t1);
      assign dly  = cfg_r[n][CFG_DLY_LSB +: DLY_W];
      assign ign  = cfg_r[n][CFG_IGNORE];
      // delay applies per direction; a zero count means no delay at all
      assign want_dly = (res_nxt ? cfg_r[n][CFG_DLY_ASSERT] : cfg_r[n][CFG_DLY_DEASSERT])
                        && (dly != '0);

      // delay engine
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          res_r[n] <= 1'b0;
          out_r[n] <= 1'b0;
          pend_r   <= 1'b0;
          tgt_r    <= 1'b0;
          cnt_r    <= '0;
        end else begin
          res_r[n] <= res_nxt;
          if (pend_r) begin
            if (!ign && (res_nxt == out_r[n])) begin
              pend_r <= 1'b0;  // reverted in time: drop the change
            end else if (cnt_r >= dly) begin
              // in ignore mode the target stands even if the result went back
              out_r[n] <= tgt_r;
              pend_r   <= 1'b0;
            end else if (tick) begin
              cnt_r <= cnt_r + 1'b1;
            end
          end else if (res_nxt != out_r[n]) begin
            if (want_dly) begin
              pend_r <= 1'b1;  // start afresh on every new change
              tgt_r  <= res_nxt;
              cnt_r  <= '0;
            end else begin
              out_r[n] <= res_nxt;  // no delay in this direction
            end
          end
        end
      end
    end
  endgenerate

  assign logic_out_o = out_r;

  // fault on deassertion of the fault-enabled input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpi_act_d_r <= '0;
      fault_r     <= 1'b0;
    end else begin
      gpi_act_d_r <= gpi_act;
      fault_r     <= fn_fault[FN_VALID] & gpi_act_d_r[fn_fault[2:0]]
                     & ~gpi_act[fn_fault[2:0]];
    end
  end
  assign fault_o = fault_r;

  // margin controls: low select only matters while margin enable holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mrg_en_r  <= 1'b0;
      mrg_low_r <= 1'b0;
    end else begin
      mrg_en_r  <= men_in;
      mrg_low_r <= men_in & mlow_in;  // low when asserted, high otherwise
    end
  end
  assign margin_en_o  = mrg_en_r;
  assign margin_low_o = mrg_low_r;

  // rail state selection from the first three defined inputs, whatever else they do
  always_comb begin
    logic [1:0] k;
    k       = '0;
    sel_nxt = '0;
    for (int i = 0; i < NUM_GPI; i++) begin
      if (polarity_r[DEF_LSB + i] && (k < 2'(NUM_SEL))) begin
        sel_nxt[k] = gpi_act[i];
        k          = k + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_r <= '0;
    end else begin
      sel_r <= sel_nxt;
    end
  end
  assign pin_chosen_rail_state_o = sel_r;

  // latched rail flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_r <= '0;
    end else begin
      logic [NUM_RAIL-1:0] clr;
      clr = '0;
      if (wr_fire && (adr_i == ADR_LATCH)) begin
        clr = NUM_RAIL'(merge_sel('0, dat_i, sel_i));
      end
      if (clr_in) begin
        clr = '1;  // clear-source input held asserted
      end
      latched_r <= (latched_r & ~clr) | rail_event_i;
    end
  end

  // sticky fault flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_flag_r <= 1'b0;
    end else if (fault_r) begin
      fault_flag_r <= 1'b1;
    end else if (wr_fire && (adr_i == ADR_STATUS) && sel_i[0] && dat_i[ST_FAULT]) begin
      fault_flag_r <= 1'b0;
    end
  end

  // configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      polarity_r <= POLARITY_RST;
      func_r     <= '0;
      for (int i = 0; i < NUM_OUT; i++) begin
        term0_r[i] <= '0;
        term1_r[i] <= '0;
        cfg_r[i]   <= '0;
      end
    end else if (wr_fire) begin
      if (adr_i == ADR_POLARITY) begin
        polarity_r <= merge_sel(polarity_r, dat_i, sel_i) & {16'h0000, 16'hFFFF};
      end else if (adr_i == ADR_FUNC) begin
        func_r <= merge_sel(func_r, dat_i, sel_i) & {16'h0000, 16'hFFFF};
      end else if (wslot[5]) begin
        unique case (wslot[1:0])
          SUB_TERM0: term0_r[wslot[4:2]] <= merge_sel(term0_r[wslot[4:2]], dat_i, sel_i);
          SUB_TERM1: term1_r[wslot[4:2]] <= merge_sel(term1_r[wslot[4:2]], dat_i, sel_i);
          SUB_CFG:   cfg_r[wslot[4:2]]   <= merge_sel(cfg_r[wslot[4:2]], dat_i, sel_i);
          default:   ;  // fourth word of a block is unmapped
        endcase
      end
    end
  end

  // read data, registered with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (bus_req && !we_i) begin
      dat_r <= '0;  // unmapped addresses read zero
      if (adr_i == ADR_POLARITY) begin
        dat_r <= polarity_r;
      end else if (adr_i == ADR_FUNC) begin
        dat_r <= func_r;
      end else if (adr_i == ADR_STATUS) begin
        dat_r[ST_FAULT]                 <= fault_flag_r;
        dat_r[ST_GPI_LSB +: NUM_GPI]    <= gpi_act;
        dat_r[ST_OUT_LSB +: NUM_OUT]    <= out_r;
        dat_r[ST_MRG_EN]                <= mrg_en_r;
        dat_r[ST_MRG_LOW]               <= mrg_low_r;
        dat_r[ST_SEL_LSB +: NUM_SEL]    <= sel_r;
      end else if (adr_i == ADR_LATCH) begin
        dat_r[NUM_RAIL-1:0] <= latched_r;
      end else if (wslot[5]) begin
        unique case (wslot[1:0])
          SUB_TERM0: dat_r <= term0_r[wslot[4:2]];
          SUB_TERM1: dat_r <= term1_r[wslot[4:2]];
          SUB_CFG:   dat_r <= cfg_r[wslot[4:2]];
          default:   dat_r <= '0;
        endcase
      end
    end
  end

  // acknowledge every request once, mapped or not, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end
  assign ack_o = ack_r;
  assign dat_o = dat_r;
endmodule : logic_out_block

//--- verification/logic_out_checker.sv
`timescale 1ns/10ps
module logic_out_checker
  import logic_out_pkg::*;
#(
  parameter int TICK_CYCLES_P = 10  // handed on from the block
) (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         cyc_i,
  input wire logic         stb_i,
  input wire logic         we_i,
  input wire logic [7:0]   adr_i,
  input wire logic [3:0]   sel_i,
  input wire logic [31:0]  dat_i,
  input wire logic [31:0]  dat_o,
  input wire logic         ack_o,
  input wire logic [7:0]   gpi_pin_i,
  input wire logic [9:0]   rail_status_i,
  input wire logic [9:0]   rail_event_i,
  input wire logic [7:0]   logic_out_o,
  input wire logic         fault_o,
  input wire logic         margin_en_o,
  input wire logic         margin_low_o,
  input wire logic [2:0]   pin_chosen_rail_state_o
);
  logic [7:0] pins_r;   // pins one cycle ago
  logic [3:0] quiet_r;  // cycles since pins or bus last moved, saturating
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // pin-driven outputs may only move shortly after a pin or bus cause
  always_ff @(posedge clk_i) begin
    pins_r <= gpi_pin_i;
    if (rst_i || pins_r != gpi_pin_i || (cyc_i && stb_i)) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  sequence s_answer; ack_o ##1 !ack_o; endsequence
  property p_ack; s_take |=> s_answer; endproperty
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i && !ack_o); endproperty
  property p_reset; $fell(rst_i) |-> logic_out_o == 8'h00 && !fault_o && !margin_en_o && !ack_o; endproperty
  property p_fault_pulse; fault_o |=> !fault_o; endproperty
  property p_fault_cause; fault_o |-> quiet_r < 4'hC; endproperty
  property p_low_en; margin_low_o |-> margin_en_o; endproperty
  property p_mrg_cause; !$stable({margin_en_o, margin_low_o}) |-> quiet_r < 4'hA; endproperty
  property p_sel_cause; !$stable(pin_chosen_rail_state_o) |-> quiet_r < 4'hA; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after take");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault longer than one cycle");
  a_fault_cause: assert property (p_fault_cause) else $error("fault without pin change");
  a_low_en: assert property (p_low_en) else $error("margin low without enable");
  a_mrg_cause: assert property (p_mrg_cause) else $error("margin moved without pin change");
  a_sel_cause: assert property (p_sel_cause) else $error("rail state moved without pin change");
endmodule : logic_out_checker

bind logic_out_block logic_out_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .gpi_pin_i, .rail_status_i, .rail_event_i, .logic_out_o,
  .fault_o, .margin_en_o, .margin_low_o, .pin_chosen_rail_state_o);

//--- verification/pin_driver.sv
`timescale 1ns/10ps
// system logic outside: drives the pins, times one logic output
module pin_driver (
  input  wire logic        clk_i,
  input  wire logic [7:0]  want_i,
  input  wire logic        watch_i,
  output logic      [7:0]  gpi_pin_o = 8'h00,
  output logic      [15:0] width_o = 16'h0000
);
  logic [15:0] cnt_r = 16'h0000;  // length of the running high pulse
  // pins move only at a clock edge, like a synchronous board source
  always @(posedge clk_i) begin
    gpi_pin_o <= want_i;
    if (watch_i) begin
      cnt_r <= cnt_r + 16'h1;
    end else begin
      if (cnt_r != 16'h0) width_o <= cnt_r;  // keep last finished pulse
      cnt_r <= 16'h0;
    end
  end
endmodule : pin_driver

//--- verification/logic_output_delay_and_input_functions_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module logic_output_delay_and_input_functions_bench;
  import logic_out_pkg::*;
  localparam int TK = 10;  // short tick keeps delays fast
  typedef struct packed { logic [7:0] pins; logic [2:0] sel; logic en, low, out0; } row_t;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, fault_o, margin_en_o, margin_low_o;
  logic [7:0]  adr_i = 8'h00, want = 8'h20, gpi_pin_i, logic_out_o;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [9:0]  rail_status_i = 10'h000, rail_event_i = 10'h000;
  logic [2:0]  pin_chosen_rail_state_o;
  logic [15:0] width;
  int          n_mismatch = 0, n_compared = 0, cycles = 0, i, k, t;
  // pin 3 margin enable, pin 4 low select (active low), pin 5 fault, pin 6 latch clear
  row_t rows [4] = '{'{8'h20, 3'h0, 1'b0, 1'b0, 1'b0}, '{8'h29, 3'h4, 1'b1, 1'b1, 1'b1},
                     '{8'h3E, 3'h7, 1'b1, 1'b0, 1'b0}, '{8'h32, 3'h1, 1'b0, 1'b0, 1'b0}};
  // output 4 needs path 1 on rail 4, or state machine mode could never leave false
  logic [7:0]  cfg_a [11] = '{ADR_POLARITY, ADR_FUNC, 8'h40, 8'h50, 8'h60, 8'h68, 8'h70, 8'h78, 8'h80, 8'h84,
                              8'h88};
  logic [31:0] cfg_d [11] = '{32'h0EEF, 32'hCBED, 32'h1, 32'h0401_0000, 32'h0002_0000, 32'h0003_0003,
                              32'h0004_0000, 32'h0003_0007, 32'h0008_0000, 32'h0010_0000, 32'h8};
  always #10 clk_i = ~clk_i;
  logic_out_block #(.TICK_CYCLES_P(TK)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .gpi_pin_i, .rail_status_i, .rail_event_i, .logic_out_o, .fault_o, .margin_en_o,
    .margin_low_o, .pin_chosen_rail_state_o);
  pin_driver drv (.clk_i, .want_i(want), .watch_i(logic_out_o[3]), .gpi_pin_o(gpi_pin_i), .width_o(width));
  // one classic cycle; the answer is sampled at the edge after ack shows
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
    do begin @(negedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) `CHK("ack", 1'b1, ack_o)
    @(posedge clk_i);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask : bus
  // cycles until an output reaches a level, capped
  task automatic measure(input int b, input logic v);
    t = 0;
    do begin @(negedge clk_i); t++; end while (logic_out_o[b] !== v && t < 80);
  endtask : measure
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // hang guard: whole run is about four hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin n_mismatch++; summarize(); end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    bus(0, ADR_POLARITY, 0); `CHK("pol_rst", POLARITY_RST, q)
    bus(1, 8'h4C, 32'hFFFF_FFFF); bus(0, 8'h4C, 0); `CHK("unmapped", 32'h0, q)
    for (i = 0; i < 11; i++) bus(1, cfg_a[i], cfg_d[i]);
    for (i = 0; i < 4; i++) begin
      want <= rows[i].pins;
      repeat (10) @(posedge clk_i);
      `CHK("sel", rows[i].sel, pin_chosen_rail_state_o)
      `CHK("mrg_en", rows[i].en, margin_en_o)
      `CHK("mrg_low", rows[i].low, margin_low_o)
      `CHK("out0", rows[i].out0, logic_out_o[0])
    end
    $display("pin table done");
    want <= 8'h12; k = 0;
    repeat (20) begin @(negedge clk_i); if (fault_o === 1'b1) k++; end
    `CHK("fault_cnt", 1, k)
    bus(0, ADR_STATUS, 0); `CHK("fault_sticky", 1'b1, q[ST_FAULT])
    bus(1, ADR_STATUS, 32'h1); bus(0, ADR_STATUS, 0); `CHK("fault_clr", 1'b0, q[ST_FAULT])
    $display("fault test done");
    want <= 8'h32; rail_event_i[0] <= 1; @(posedge clk_i); rail_event_i[0] <= 0;
    repeat (12) @(posedge clk_i); `CHK("latched", 1'b1, logic_out_o[1])
    bus(0, ADR_LATCH, 0); `CHK("latch_reg", 32'h1, q)
    want <= 8'h72; repeat (10) @(posedge clk_i); `CHK("pin_clear", 1'b0, logic_out_o[1])
    // let the clear pin settle inactive first, else it wipes the new event by itself
    want <= 8'h32; repeat (10) @(posedge clk_i); rail_event_i[0] <= 1; @(posedge clk_i); rail_event_i[0] <= 0;
    repeat (3) @(posedge clk_i); `CHK("relatch", 1'b1, logic_out_o[1])
    bus(1, ADR_LATCH, 32'h1); repeat (3) @(posedge clk_i);
    `CHK("bus_clear", 1'b0, logic_out_o[1])
    $display("latch test done");
    rail_status_i[1] <= 1; repeat (12) @(posedge clk_i); rail_status_i[1] <= 0;
    k = 0;
    repeat (40) begin @(negedge clk_i); if (logic_out_o[2] === 1'b1) k++; end
    `CHK("glitch", 0, k)
    @(posedge clk_i); rail_status_i[1] <= 1; measure(2, 1'b1);
    `CHK("assert_delay", 1'b1, t >= 19 && t <= 35)
    @(posedge clk_i); rail_status_i[1] <= 0; measure(2, 1'b0);
    `CHK("deassert_delay", 1'b1, t >= 19 && t <= 35)
    $display("delay test done");
    @(posedge clk_i); rail_status_i[2] <= 1; repeat (3) @(posedge clk_i); rail_status_i[2] <= 0;
    measure(3, 1'b1); `CHK("short_pulse", 1'b1, t >= 14 && t <= 35)
    measure(3, 1'b0); @(posedge clk_i); @(posedge clk_i);
    `CHK("min_width", 1'b1, width >= 16'(2 * TK))
    $display("ignore test done");
    rail_status_i[3] <= 1; repeat (5) @(posedge clk_i); `CHK("sm_idle", 1'b0, logic_out_o[4])
    rail_status_i[4] <= 1; repeat (5) @(posedge clk_i); `CHK("sm_set", 1'b1, logic_out_o[4])
    rail_status_i[4] <= 0; repeat (5) @(posedge clk_i); `CHK("sm_hold", 1'b1, logic_out_o[4])
    rail_status_i[3] <= 0; repeat (5) @(posedge clk_i); `CHK("sm_drop", 1'b0, logic_out_o[4])
    $display("state machine test done");
    rst_i <= 1; repeat (2) @(posedge clk_i); rst_i <= 0; @(negedge clk_i);
    `CHK("rst_out", 8'h00, logic_out_o)
    bus(0, ADR_POLARITY, 0); `CHK("rst_pol", POLARITY_RST, q)
    $display("second reset done");
    summarize();
  end
endmodule : logic_output_delay_and_input_functions_bench
